/* File: verif/tb.sv */
// Bench for the watchdog reset timer: APB access, reset pulse timing.
// Assumes wdrt_pkg compiled first; prescaler cut to 16 clocks.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic        halt_exec = 1'b0, ext_wake = 1'b0, pready, pslverr, reset_out_n, er;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rd, v;
    int          fail_count = 0, samples_checked = 0, n;
    // Design, short prescaler
    wdrt_top #(.PRESCALE(16)) dut (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .halt_exec(halt_exec), .ext_wake(ext_wake),
        .reset_out_n(reset_out_n));
    // 125 MHz clock
    initial forever #4 pclk = ~pclk;
    // Count and report one comparison
    task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
        samples_checked++;
        fail_count += int'(g !== e);
        if (g !== e) $display("BAD %s expected %h seen %h", nm, e, g);
    endtask
    // One APB transfer, held until pready is seen
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        {er, rd} = {pslverr, prdata};
        {psel, penable} <= 2'b00;
    endtask
    // Reset for 20 clocks, then control word must read its reset value
    task automatic do_reset();
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        xfer(1'b0, 12'h000, 32'h0);
        cmp("ctrl_reset", {24'h0, wdrt_pkg::CTRL_RESET}, rd);
    endtask
    // Delay to the reset pulse, its width, then the system reset
    task automatic pulse(input int lo, input int hi);
        @(negedge pclk);
        for (n = 1; reset_out_n !== 1'b0 && n < 300; n++) @(negedge pclk);
        cmp("pulse_delay", 32'h1, 32'(n inside {[lo:hi]}));
        for (n = 0; reset_out_n === 1'b0 && n < 300; n++) @(negedge pclk);
        cmp("pulse_width", 32'h1, 32'((n - wdrt_pkg::PULSE_CYC) inside {0, 1}));
        do_reset();
    endtask
    // One-clock halt (h high) or wake (h low)
    task automatic strobe(input logic h);
        @(posedge pclk);
        {halt_exec, ext_wake} <= {h, ~h};
        @(posedge pclk);
        {halt_exec, ext_wake} <= 2'b00;
    endtask
    // Two control reads 64 clocks apart, into v then rd
    task automatic gap();
        xfer(1'b0, 12'h000, 32'h0);
        v = rd;
        repeat (61) @(posedge pclk);
        xfer(1'b0, 12'h000, 32'h0);
    endtask
    // Verdict and end of run
    task automatic end_of_test(input int extra);
        fail_count += extra;
        $display("Checks %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask
    // Hang guard, far past the expected run
    initial #200000 end_of_test(1);
    // Test sequence
    initial
    begin
        do_reset();
        xfer(1'b0, 12'h00C, 32'h0);
        cmp("unmapped", 32'h8000_0000, {er, rd[30:0]});
        gap();
        cmp("ctrl_free_run", v - 32'h4, rd);
        xfer(1'b1, 12'h000, 32'h41);
        repeat (40) @(posedge pclk);
        @(negedge pclk);
        cmp("wrap_no_reset", 32'h1, {31'h0, reset_out_n});
        xfer(1'b0, 12'h000, 32'h0);
        cmp("ctrl_wrapped", 32'h1, 32'(rd[7:0] inside {[8'h3C:8'h3F]}));
        xfer(1'b1, 12'h000, 32'hC5);
        xfer(1'b1, 12'h000, 32'h45);
        pulse(81, 100);
        xfer(1'b1, 12'h000, 32'h80);
        pulse(1, 3);
        xfer(1'b1, 12'h000, 32'hFF);
        strobe(1'b1);
        repeat (20) @(posedge pclk);
        gap();
        cmp("ctrl_halted", v, rd);
        xfer(1'b0, 12'h008, 32'h0);
        cmp("stat_halted", 32'h3, rd);
        strobe(1'b0);
        gap();
        cmp("ctrl_woken", v - 32'h4, rd);
        xfer(1'b1, 12'h004, 32'h2);
        strobe(1'b1);
        pulse(1, 4);
        xfer(1'b1, 12'h004, 32'h1);
        xfer(1'b1, 12'h000, 32'h41);
        pulse(17, 37);
        end_of_test(0);
    end
endmodule

/* File: verilog/wdrt_pkg.sv */
// Package for the watchdog reset timer: register map, reset values, timing.
// Assumes a 125 MHz APB clock standing in for the core oscillator clock.
package wdrt_pkg;
    // Register map (byte addresses)
    localparam logic [11:0] CTRL_ADDR    = 12'h000;
    localparam logic [11:0] OPT_ADDR     = 12'h004;
    localparam logic [11:0] STAT_ADDR    = 12'h008;
    // Control word layout and reset value
    localparam int          ACT_BIT      = 7;
    localparam int          TOP_BIT      = 6;
    localparam logic [7:0]  CTRL_RESET   = 8'h7F;
    // Option register layout (hardware watchdog, halt reset, osc irq enable)
    localparam int          OPT_HW_BIT   = 0;
    localparam int          OPT_HALT_BIT = 1;
    localparam int          OPT_OIE_BIT  = 2;
    localparam logic [2:0]  OPT_RESET    = 3'h0;
    // Counter roll-over points
    localparam logic [6:0]  ROLL_FROM    = 7'h40;
    localparam logic [6:0]  ROLL_TO      = 7'h3F;
    // Timing
    localparam int          PRESCALE     = 16384;
    localparam int          CLK_PS       = 8000;
    localparam int          PULSE_NS     = 500;
    localparam int          PULSE_CYC    = (PULSE_NS * 1000) / CLK_PS;
    // Halt state of the counter
    typedef enum logic [1:0] {WDRT_RUN, WDRT_HALT_ONE, WDRT_STOPPED} wdrt_halt_t;
    // APB request bundle
    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } wdrt_apb_req_t;
endpackage

/* File: verilog/wdrt_top.sv */
// Watchdog reset timer: 7-bit down-counter with prescaler, reset pulse out.
// Assumes an APB master on pclk; halt and wake come from the core as pulses.
// How it works
// - Seven-bit counter steps every 16384 clocks
// - Low six bits set 64 timeout steps
// - Active and 40h to 3Fh starts reset
// - Reset pin pulled low about 500ns
// - Counter runs even when not activated
// - Prescaler not cleared on write
// - Not activated after any reset
// - Activation sticky until reset
// - Active write with top bit clear resets
// - Halt while active resets per option
// - Hardware watchdog option selectable
// - Control word resets to 7Fh
// - Hardware option forces active, ignores bit
// - Halt with halt and irq options clear: one step, stop
module wdrt_top #(
    parameter int PRESCALE = wdrt_pkg::PRESCALE
) (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        halt_exec,
    input  wire logic        ext_wake,
    output logic             reset_out_n
);
    localparam int PW = $clog2(PRESCALE);

    wdrt_pkg::wdrt_apb_req_t req;
    logic [7:0]              ctrl_q;
    logic [2:0]              opt_q;
    logic [PW-1:0]           pre_q;
    logic [7:0]              pulse_q;
    logic                    wdreset_q;
    wdrt_pkg::wdrt_halt_t    halt_q;
    wdrt_pkg::wdrt_halt_t    halt_d;
    logic [7:0]              low_cnt_q;
    logic                    boot_q;

    assign req = '{psel, penable, pwrite, paddr, pwdata};

    // Bus decode
    wire acc      = req.psel & req.penable;
    wire wr       = acc & req.pwrite;
    wire hit_ctrl = req.paddr == wdrt_pkg::CTRL_ADDR;
    wire hit_opt  = req.paddr == wdrt_pkg::OPT_ADDR;
    wire hit_stat = req.paddr == wdrt_pkg::STAT_ADDR;
    wire mapped   = hit_ctrl | hit_opt | hit_stat;
    wire wr_ctrl  = wr & hit_ctrl;
    wire wr_opt   = wr & hit_opt;

    // Watchdog state
    wire hw_mode  = opt_q[wdrt_pkg::OPT_HW_BIT];
    wire active   = ctrl_q[wdrt_pkg::ACT_BIT] | hw_mode;
    wire counting = halt_q != wdrt_pkg::WDRT_STOPPED;
    wire tick     = counting & (pre_q == PW'(PRESCALE - 1));
    wire roll     = tick & (ctrl_q[6:0] == wdrt_pkg::ROLL_FROM);
    wire [7:0] wval = pwdata[7:0];
    wire act_new  = wval[wdrt_pkg::ACT_BIT] | ctrl_q[wdrt_pkg::ACT_BIT];
    wire sw_reset = wr_ctrl & (act_new | hw_mode) & ~wval[wdrt_pkg::TOP_BIT];
    wire halt_rst = halt_exec & active & opt_q[wdrt_pkg::OPT_HALT_BIT];
    wire halt_stop = halt_exec & ~opt_q[wdrt_pkg::OPT_HALT_BIT]
                     & ~opt_q[wdrt_pkg::OPT_OIE_BIT];
    wire rst_req  = (roll & active) | sw_reset | halt_rst;

    // Read mux and APB answers
    assign pready  = 1'b1;
    assign pslverr = acc & ~mapped;
    assign prdata  = ~acc         ? 32'h0000_0000 :
                     hit_ctrl     ? {24'h00_0000, ctrl_q} :
                     hit_opt      ? {29'h0000_0000, opt_q} :
                     hit_stat     ? {30'h0000_0000, halt_q == wdrt_pkg::WDRT_STOPPED, active} :
                                    32'h0000_0000;

    // Prescaler never cleared by writes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            pre_q <= '0;
        else if (counting)
            pre_q <= tick ? '0 : pre_q + PW'(1);
    end

    // Control word: load on write, decrement on tick
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            ctrl_q <= wdrt_pkg::CTRL_RESET;
        else if (wr_ctrl)
            ctrl_q <= {act_new, wval[6:0]};
        else if (tick)
            ctrl_q[6:0] <= ctrl_q[6:0] - 7'h01;
    end

    // Option register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            opt_q <= wdrt_pkg::OPT_RESET;
        else if (wr_opt)
            opt_q <= wval[2:0];
    end

    // Halt tracking: one more step then stop until wake
    always_comb
    begin
        halt_d = halt_q;
        case (halt_q)
            wdrt_pkg::WDRT_RUN:      if (halt_stop) halt_d = wdrt_pkg::WDRT_HALT_ONE;
            wdrt_pkg::WDRT_HALT_ONE: if (ext_wake) halt_d = wdrt_pkg::WDRT_RUN;
                                     else if (tick) halt_d = wdrt_pkg::WDRT_STOPPED;
            wdrt_pkg::WDRT_STOPPED:  if (ext_wake) halt_d = wdrt_pkg::WDRT_RUN;
            default:                 halt_d = wdrt_pkg::WDRT_RUN;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            halt_q <= wdrt_pkg::WDRT_RUN;
        else
            halt_q <= halt_d;
    end

    // Reset pulse generator
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pulse_q   <= 8'h00;
            wdreset_q <= 1'b0;
        end
        else if (rst_req && !wdreset_q)
        begin
            pulse_q   <= 8'(wdrt_pkg::PULSE_CYC - 1);
            wdreset_q <= 1'b1;
        end
        else if (wdreset_q)
        begin
            pulse_q   <= pulse_q - 8'h01;
            wdreset_q <= pulse_q != 8'h00;
        end
    end

    assign reset_out_n = ~wdreset_q;

    // Length of the current low pulse, for the checks below
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            low_cnt_q <= 8'h00;
        else if (!reset_out_n)
            low_cnt_q <= low_cnt_q + 8'h01;
        else
            low_cnt_q <= 8'h00;
    end

    // First clock after a reset release, for the reset value checks
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            boot_q <= 1'b1;
        else
            boot_q <= 1'b0;
    end

    // Pulse never outlasts its length
    AST_PULSE_LEN: assert property (@(posedge pclk) disable iff (!presetn)
        !reset_out_n |-> low_cnt_q < 8'(wdrt_pkg::PULSE_CYC))
        else $error("reset pulse too long");

    // Pulse ends after exactly its length
    AST_PULSE_END: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(reset_out_n) |-> low_cnt_q == 8'(wdrt_pkg::PULSE_CYC))
        else $error("reset pulse too short");
    // Active roll-over starts a pulse on the next clock
    AST_ROLL_RESET: assert property (@(posedge pclk) disable iff (!presetn)
        (roll && active && reset_out_n) |=> !reset_out_n)
        else $error("no reset on roll-over");

    // Activation bit never falls outside reset
    AST_STICKY: assert property (@(posedge pclk) disable iff (!presetn)
        ctrl_q[7] |=> ctrl_q[7])
        else $error("activation bit cleared");

    // Each tick without a control write takes one off the counter
    AST_DECR: assert property (@(posedge pclk) disable iff (!presetn)
        (tick && !wr_ctrl) |=> ctrl_q[6:0] == $past(ctrl_q[6:0]) - 7'h01)
        else $error("counter did not decrement");

    // No pulse without a request
    AST_NO_SPURIOUS: assert property (@(posedge pclk) disable iff (!presetn)
        (reset_out_n && !rst_req) |=> reset_out_n)
        else $error("reset without cause");

    // Active write with the top bit clear starts a pulse
    AST_SWRST: assert property (@(posedge pclk) disable iff (!presetn)
        (sw_reset && reset_out_n) |=> !reset_out_n)
        else $error("software reset missed");

    // Write loads the seven counter bits
    AST_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
        wr_ctrl |=> ctrl_q[6:0] == $past(pwdata[6:0]))
        else $error("write not loaded");

    // Halt while active with the reset option starts a pulse
    AST_HALT: assert property (@(posedge pclk) disable iff (!presetn)
        (halt_rst && reset_out_n) |=> !reset_out_n)
        else $error("halt reset missed");

    // Stopped counter holds unless written
    AST_STOP: assert property (@(posedge pclk) disable iff (!presetn)
        (halt_q == wdrt_pkg::WDRT_STOPPED && !ext_wake) |=> $stable(ctrl_q[6:0]) || $past(wr_ctrl))
        else $error("counter ran while stopped");

    // Counter moves only on a prescaler tick or a write
    AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        (!tick && !wr_ctrl) |=> $stable(ctrl_q[6:0]))
        else $error("counter moved without tick");

    // Tick is a single-cycle enable
    AST_TICK_ONE: assert property (@(posedge pclk) disable iff (!presetn)
        tick |=> !tick)
        else $error("tick longer than one clock");

    // Top bit written high stays high after the load
    AST_TOP_KEPT: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_ctrl && pwdata[wdrt_pkg::TOP_BIT]) |=> ctrl_q[wdrt_pkg::TOP_BIT])
        else $error("top bit lost on load");

    // Prescaler keeps its phase across a write
    AST_PRE_KEEP: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_ctrl && counting && !tick) |=> pre_q == $past(pre_q) + PW'(1))
        else $error("prescaler disturbed by write");

    // First clock after reset shows the reset control word
    AST_BOOT_CTRL: assert property (@(posedge pclk) disable iff (!presetn)
        boot_q |-> ctrl_q == wdrt_pkg::CTRL_RESET)
        else $error("control word reset value wrong");

    // First clock after reset: disabled, no pulse, counter running
    AST_BOOT_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
        boot_q |-> (!active && reset_out_n && halt_q == wdrt_pkg::WDRT_RUN))
        else $error("watchdog active after reset");

    // Write with the activation bit set enables the watchdog
    AST_ACT_SET: assert property (@(posedge pclk) disable iff (!presetn)
        (wr_ctrl && pwdata[wdrt_pkg::ACT_BIT]) |=> ctrl_q[wdrt_pkg::ACT_BIT])
        else $error("activation bit not set");

    // Hardware option resets on roll-over whatever the activation bit
    AST_HW_ROLL: assert property (@(posedge pclk) disable iff (!presetn)
        (hw_mode && roll && reset_out_n) |=> !reset_out_n)
        else $error("hardware mode missed roll-over");

    // Roll-over while disabled only wraps the counter
    AST_IDLE_WRAP: assert property (@(posedge pclk) disable iff (!presetn)
        (roll && !active && !wr_ctrl && !halt_rst && reset_out_n)
            |=> (reset_out_n && ctrl_q[6:0] == wdrt_pkg::ROLL_TO))
        else $error("disabled counter did not wrap quietly");

    // Option word takes the written value
    AST_OPT_LOAD: assert property (@(posedge pclk) disable iff (!presetn)
        wr_opt |=> opt_q == $past(pwdata[2:0]))
        else $error("option word not loaded");

    // Halt with the reset and irq options clear: one more step, then stopped
    AST_ONE_STEP: assert property (@(posedge pclk) disable iff (!presetn)
        (halt_q == wdrt_pkg::WDRT_HALT_ONE && tick && !ext_wake)
            |=> halt_q == wdrt_pkg::WDRT_STOPPED)
        else $error("counter did not stop after one step");

    // Wake pulse restarts a halted counter at once
    AST_WAKE: assert property (@(posedge pclk) disable iff (!presetn)
        (halt_q != wdrt_pkg::WDRT_RUN && ext_wake) |=> halt_q == wdrt_pkg::WDRT_RUN)
        else $error("counter not restarted by wake");

    // Halt without the reset option never starts a pulse by itself
    AST_HALT_QUIET: assert property (@(posedge pclk) disable iff (!presetn)
        (halt_exec && !opt_q[wdrt_pkg::OPT_HALT_BIT] && !(roll && active) && !sw_reset
            && reset_out_n) |=> reset_out_n)
        else $error("halt reset without option");

    // Activation bit after a write is the OR of old and new
    AST_OR_ACT: assert property (@(posedge pclk) disable iff (!presetn)
        wr_ctrl |=> ctrl_q[wdrt_pkg::ACT_BIT] == ($past(pwdata[7]) | $past(ctrl_q[7])))
        else $error("activation bit not merged");

    // Roll-over request lasts a single clock
    AST_ROLL_ONCE: assert property (@(posedge pclk) disable iff (!presetn)
        roll |=> !roll)
        else $error("roll-over request held too long");

    // Requests during a pulse do not cut or restart it
    AST_BUSY_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        (!reset_out_n && pulse_q != 8'h00) |=> !reset_out_n)
        else $error("pulse cut short");
endmodule
